// ==== include/pgp_pkg.sv ====
// Package for the port 1 shared-pin GPIO block
`default_nettype none
package pgp_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [15:0] ADDR_LATCH = 16'hFE44;
	localparam logic [15:0] ADDR_DIR = 16'hFE45;
	localparam logic [15:0] ADDR_FUNC = 16'hFE46;
	localparam logic [15:0] ADDR_TEST = 16'hFE47;
	localparam logic [15:0] ADDR_INSEL = 16'hFE5F;
	localparam logic [7:0] RST_PORT = 8'h00;
	// Flash build holds bit 5 driven low while in reset
	localparam logic [7:0] RST_OE_FLASH = 8'h20;
	// Test register: writable bits and their positions
	localparam logic [7:0] TEST_WMASK = 8'h24;
	localparam int TEST_RCOSC_BIT = 5;
	localparam int TEST_HSOUT_BIT = 2;
	localparam int INSEL_BUZ_BIT = 3;
	// Bits that read high in the test register
	localparam logic [7:0] TEST_RD_ONES = 8'h0A;
	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic pwm_high_output;
		logic pwm_low_output;
		logic buzzer_output;
		logic serial_channel_one_clk;
		logic serial_channel_one_dout_b4;
		logic serial_channel_one_dout_b3;
		logic serial_channel_zero_clk;
		logic serial_channel_zero_dout_b1;
		logic serial_channel_zero_dout_b0;
	} pgp_periph_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic rmw;
	} pgp_bus_t;
endpackage : pgp_pkg
`default_nettype wire

// ==== rtl/pgp_port1.sv ====
// Port 1 eight-bit GPIO with shared peripheral output functions
`timescale 1ns/1ns
`default_nettype none
module pgp_port1 #(
	parameter logic [7:0] OPEN_DRAIN = 8'h00, // Per-bit build option, 1 = open drain
	parameter bit FLASH_VARIANT = 1'b1 // Flash build drives bit 5 low in reset
) (
	input wire logic clk_sys, // 125 MHz system clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire pgp_pkg::pgp_bus_t bus, // CPU register access
	output logic [7:0] rd_data, // Read data, cycle after read strobe
	input wire logic [7:0] pin_in, // Pin levels
	output logic [7:0] pin_out, // Pin output value
	output logic [7:0] pin_oe, // Pin output enable
	output logic [7:0] pullup_en, // Internal pull-up enable
	input wire pgp_pkg::pgp_periph_t periph, // Peripheral output signals
	input wire logic serial_channel_one_active, // Serial channel 1 running
	input wire logic serial_channel_zero_active, // Serial channel 0 running
	output logic serial_channel_one_din, // Serial channel 1 input data
	output logic serial_channel_zero_din, // Serial channel 0 input data
	input wire logic low_power_hold, // Halt or hold mode active
	output logic hs_counter_realtime_out_en, // High-speed counter output enable
	output logic rc_osc_freq_ctrl // RC oscillator control
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] latch_reg, latch_next;
	logic [7:0] dir_reg, dir_next;
	logic [7:0] func_reg, func_next;
	logic [7:0] test_reg, test_next;
	logic [7:0] insel_reg, insel_next;
	logic [7:0] rd_next;
	logic [7:0] pout_next, poe_next, pup_next;

	// One address compare feeds both the write strobes and the read mux
	function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] target);
		return addr == target;
	endfunction : addr_hit

	wire wr_latch = bus.wr && addr_hit(bus.addr, pgp_pkg::ADDR_LATCH);
	wire wr_dir = bus.wr && addr_hit(bus.addr, pgp_pkg::ADDR_DIR);
	wire wr_func = bus.wr && addr_hit(bus.addr, pgp_pkg::ADDR_FUNC);
	wire wr_test = bus.wr && addr_hit(bus.addr, pgp_pkg::ADDR_TEST);
	wire wr_insel = bus.wr && addr_hit(bus.addr, pgp_pkg::ADDR_INSEL);

	assign latch_next = wr_latch ? bus.wdata : latch_reg;
	assign dir_next = wr_dir ? bus.wdata : dir_reg;
	assign func_next = wr_func ? bus.wdata : func_reg;
	// Reserved test bits are held at zero whatever software writes
	assign test_next = wr_test ? (bus.wdata & pgp_pkg::TEST_WMASK) : test_reg;
	assign insel_next = wr_insel ? bus.wdata : insel_reg;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	wire [7:0] data_read = bus.rmw ? latch_reg : pin_in;
	assign rd_next = !bus.rd ? 8'h00 :
		addr_hit(bus.addr, pgp_pkg::ADDR_LATCH) ? data_read :
		addr_hit(bus.addr, pgp_pkg::ADDR_DIR) ? dir_reg :
		addr_hit(bus.addr, pgp_pkg::ADDR_FUNC) ? func_reg :
		addr_hit(bus.addr, pgp_pkg::ADDR_TEST) ? (test_reg | pgp_pkg::TEST_RD_ONES) :
		addr_hit(bus.addr, pgp_pkg::ADDR_INSEL) ? insel_reg : 8'h00;

	// ----------------------------------------
	// Pin function mux
	// ----------------------------------------
	wire buz_sel = insel_reg[pgp_pkg::INSEL_BUZ_BIT];
	wire b7_src = buz_sel ? periph.buzzer_output : periph.pwm_high_output;
	wire [7:0] periph_bits = {b7_src, periph.pwm_low_output, periph.serial_channel_one_clk,
		periph.serial_channel_one_dout_b4, periph.serial_channel_one_dout_b3, periph.serial_channel_zero_clk,
		periph.serial_channel_zero_dout_b1, periph.serial_channel_zero_dout_b0};
	logic [7:0] drive_val;

	// Bits 7 and 6 invert by latch, bits 5..0 OR with latch
	always_comb begin
		drive_val[7] = func_reg[7] ? (periph_bits[7] ^ latch_reg[7]) : latch_reg[7];
		drive_val[6] = func_reg[6] ? (periph_bits[6] ^ latch_reg[6]) : latch_reg[6];
		drive_val[5:0] = (func_reg[5:0] & periph_bits[5:0]) | latch_reg[5:0];
	end

	// Open drain releases the pin for high, CMOS drives it
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pin
			assign pout_next[g] = drive_val[g];
			assign poe_next[g] = dir_reg[g] && !(OPEN_DRAIN[g] && drive_val[g]);
			assign pup_next[g] = !dir_reg[g] && latch_reg[g];
		end
	endgenerate

	// ----------------------------------------
	// Sequential logic
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			latch_reg <= pgp_pkg::RST_PORT;
			dir_reg <= pgp_pkg::RST_PORT;
			func_reg <= pgp_pkg::RST_PORT;
			test_reg <= pgp_pkg::RST_PORT;
			insel_reg <= pgp_pkg::RST_PORT;
			rd_data <= 8'h00;
		end else begin
			latch_reg <= latch_next;
			dir_reg <= dir_next;
			func_reg <= func_next;
			test_reg <= test_next;
			insel_reg <= insel_next;
			rd_data <= rd_next;
		end
	end

	// ----------------------------------------
	// Pin outputs
	// ----------------------------------------
	// Pins freeze in low power; in reset the flash build pulls bit 5 low
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pin_out <= 8'h00;
			pin_oe <= FLASH_VARIANT ? pgp_pkg::RST_OE_FLASH : pgp_pkg::RST_PORT;
			pullup_en <= 8'h00;
		end else if (!low_power_hold) begin
			pin_out <= pout_next;
			pin_oe <= poe_next;
			pullup_en <= pup_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			serial_channel_one_din <= 1'b0;
			serial_channel_zero_din <= 1'b0;
			hs_counter_realtime_out_en <= 1'b0;
			rc_osc_freq_ctrl <= 1'b0;
		end else begin
			// Sampled regardless of direction so a channel can listen on an output pin
			serial_channel_one_din <= serial_channel_one_active ? pin_in[4] : 1'b0;
			serial_channel_zero_din <= serial_channel_zero_active ? pin_in[1] : 1'b0;
			hs_counter_realtime_out_en <= test_next[pgp_pkg::TEST_HSOUT_BIT];
			rc_osc_freq_ctrl <= test_next[pgp_pkg::TEST_RCOSC_BIT];
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_dir_oe;
		@(posedge clk_sys) disable iff (!rst_n)
		(!low_power_hold && !dir_reg[0]) |=> !pin_oe[0];
	endproperty
	a_dir_oe: assert property (p_dir_oe) else $error("Input bit driven");

	property p_pullup;
		@(posedge clk_sys) disable iff (!rst_n)
		!low_power_hold |=> pullup_en == (~$past(dir_reg) & $past(latch_reg));
	endproperty
	a_pullup: assert property (p_pullup) else $error("Pull-up mismatch");

	property p_read_pins;
		@(posedge clk_sys) disable iff (!rst_n)
		(bus.rd && !bus.rmw && bus.addr == pgp_pkg::ADDR_LATCH) |=> rd_data == $past(pin_in);
	endproperty
	a_read_pins: assert property (p_read_pins) else $error("Pin read wrong");

	property p_read_rmw;
		@(posedge clk_sys) disable iff (!rst_n)
		(bus.rd && bus.rmw && bus.addr == pgp_pkg::ADDR_LATCH) |=> rd_data == $past(latch_reg);
	endproperty
	a_read_rmw: assert property (p_read_rmw) else $error("RMW read wrong");

	property p_latch_out;
		@(posedge clk_sys) disable iff (!rst_n)
		(!low_power_hold && !func_reg[3]) |=> pin_out[3] == $past(latch_reg[3]);
	endproperty
	a_latch_out: assert property (p_latch_out) else $error("Latch not output");

	property p_bit7;
		@(posedge clk_sys) disable iff (!rst_n)
		(!low_power_hold && func_reg[7]) |=> pin_out[7] == ($past(latch_reg[7]) ^
			($past(insel_reg[pgp_pkg::INSEL_BUZ_BIT]) ? $past(periph.buzzer_output)
			: $past(periph.pwm_high_output)));
	endproperty
	a_bit7: assert property (p_bit7) else $error("Bit 7 function wrong");

	property p_bit6;
		@(posedge clk_sys) disable iff (!rst_n)
		(!low_power_hold && func_reg[6] && latch_reg[6])
			|=> pin_out[6] == !$past(periph.pwm_low_output);
	endproperty
	a_bit6: assert property (p_bit6) else $error("Bit 6 not inverted");

	property p_bit5_high;
		@(posedge clk_sys) disable iff (!rst_n)
		(!low_power_hold && func_reg[5] && latch_reg[5]) |=> pin_out[5];
	endproperty
	a_bit5_high: assert property (p_bit5_high) else $error("Bit 5 not high");

	property p_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		low_power_hold[*2] |-> $stable(pin_out) && $stable(pin_oe) && $stable(pullup_en);
	endproperty
	a_hold: assert property (p_hold) else $error("Pins moved in hold");

	property p_test_zero;
		@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |-> (test_reg & ~pgp_pkg::TEST_WMASK) == 8'h00;
	endproperty
	a_test_zero: assert property (p_test_zero) else $error("Reserved test bit set");

	property p_write_next;
		@(posedge clk_sys) disable iff (!rst_n)
		wr_dir |=> dir_reg == $past(bus.wdata);
	endproperty
	a_write_next: assert property (p_write_next) else $error("Direction write lost");

	property p_oe_type;
		@(posedge clk_sys) disable iff (!rst_n)
		(rst_n && !low_power_hold && func_reg == 8'h00)
			|=> pin_oe == ($past(dir_reg) & ~(OPEN_DRAIN & $past(latch_reg)));
	endproperty
	a_oe_type: assert property (p_oe_type) else $error("Output type drive wrong");

	property p_drive_low;
		@(posedge clk_sys) disable iff (!rst_n)
		(!low_power_hold && dir_reg[2] && !func_reg[2] && !latch_reg[2]) |=> pin_oe[2] && !pin_out[2];
	endproperty
	a_drive_low: assert property (p_drive_low) else $error("Low not driven");

	property p_reset_b5;
		@(posedge clk_sys)
		!rst_n |=> pin_oe[5] == FLASH_VARIANT && !pin_out[5];
	endproperty
	a_reset_b5: assert property (p_reset_b5) else $error("Bit 5 not low in reset");

	property p_bit4_func;
		@(posedge clk_sys) disable iff (!rst_n)
		(!low_power_hold && func_reg[4] && !latch_reg[4]) |=> pin_out[4] == $past(periph.serial_channel_one_dout_b4);
	endproperty
	a_bit4_func: assert property (p_bit4_func) else $error("Bit 4 serial data wrong");

	property p_serial_channel_one_in;
		@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> serial_channel_one_din == ($past(serial_channel_one_active) && $past(pin_in[4]));
	endproperty
	a_serial_channel_one_in: assert property (p_serial_channel_one_in) else $error("Channel 1 input wrong");

	property p_serial_channel_zero_in;
		@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> serial_channel_zero_din == ($past(serial_channel_zero_active) && $past(pin_in[1]));
	endproperty
	a_serial_channel_zero_in: assert property (p_serial_channel_zero_in) else $error("Channel 0 input wrong");

	property p_test_out;
		@(posedge clk_sys) disable iff (!rst_n)
		wr_test |=> hs_counter_realtime_out_en == $past(bus.wdata[pgp_pkg::TEST_HSOUT_BIT])
			&& rc_osc_freq_ctrl == $past(bus.wdata[pgp_pkg::TEST_RCOSC_BIT]);
	endproperty
	a_test_out: assert property (p_test_out) else $error("Test bit export wrong");

	property p_rd_idle;
		@(posedge clk_sys) disable iff (!rst_n)
		!bus.rd |=> rd_data == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("Read data held too long");

	property p_write_latch;
		@(posedge clk_sys) disable iff (!rst_n)
		wr_latch |=> latch_reg == $past(bus.wdata);
	endproperty
	a_write_latch: assert property (p_write_latch) else $error("Latch write lost");

	property p_bit6_zero;
		@(posedge clk_sys) disable iff (!rst_n)
		(!low_power_hold && func_reg[6] && !latch_reg[6]) |=> pin_out[6] == $past(periph.pwm_low_output);
	endproperty
	a_bit6_zero: assert property (p_bit6_zero) else $error("Bit 6 not passed");

	c_func7: cover property (@(posedge clk_sys) disable iff (!rst_n) func_reg[7] && dir_reg[7]);
	c_rmw: cover property (@(posedge clk_sys) disable iff (!rst_n) bus.rd && bus.rmw);
	c_hold: cover property (@(posedge clk_sys) disable iff (!rst_n) low_power_hold[*3]);
	c_buz: cover property (@(posedge clk_sys) disable iff (!rst_n) func_reg[7] && insel_reg[3]);
	c_sio: cover property (@(posedge clk_sys) disable iff (!rst_n) serial_channel_one_active && serial_channel_zero_active);
endmodule : pgp_port1
`default_nettype wire

// ==== tb/pgp_board.sv ====
// Board-side model of the eight port pins
`timescale 1ns/1ns
`default_nettype none
module pgp_board #(
	parameter logic [7:0] PULL_EXT = 8'h00 // Board pull-up resistors
) (
	input wire logic clk_sys, // System clock
	input wire logic rst_n, // Reset, active low
	input wire logic [7:0] pin_out, // Device pin value
	input wire logic [7:0] pin_oe, // Device drives pin
	input wire logic [7:0] pullup_en, // Device pull-up on
	input wire logic [7:0] ext_en, // Board drives pin
	input wire logic [7:0] ext_val, // Board drive level
	output logic [7:0] pin_in // Resolved pin level
);
	logic tg;
	logic [7:0] drv, lvl;
	// Bit 3 sits at a firm high level, never a clock or a float, while in reset
	assign drv = rst_n ? ext_en : (ext_en | 8'h08);
	assign lvl = rst_n ? ext_val : (ext_val | 8'h08);
	// A floating pin shows its pull-up or a changing level, never a stale one
	always_ff @(posedge clk_sys) begin
		tg <= rst_n ? ~tg : 1'b0;
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] :
				(drv[i] ? lvl[i] : (pullup_en[i] | PULL_EXT[i] | tg));
		end
	end
endmodule : pgp_board
`default_nettype wire

// ==== tb/tb_pgp_port1.sv ====
// Self-checking bench for the port 1 GPIO block
`timescale 1ns/1ns
`default_nettype none
module tb_pgp_port1;
	logic clk_sys, rst_n, serial_channel_one_active, serial_channel_zero_active, low_power_hold;
	pgp_pkg::pgp_bus_t bus;
	pgp_pkg::pgp_periph_t periph;
	logic [7:0] rd_data, pin_in, pin_out, pin_oe, pullup_en, ext_en, ext_val;
	logic serial_channel_one_din, serial_channel_zero_din, hs_en, rc_en, rd_seen, s;
	logic [7:0] exp_q[$];
	logic [7:0] l, d, v, e;
	int n_fail = 0;
	int n_compared = 0;
	// Low nibble is open drain with a board pull-up, high nibble push-pull
	localparam logic [7:0] OD_BITS = 8'h0F;
	pgp_port1 #(.OPEN_DRAIN(OD_BITS)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
		.rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pullup_en(pullup_en), .periph(periph), .serial_channel_one_active(serial_channel_one_active),
		.serial_channel_zero_active(serial_channel_zero_active), .serial_channel_one_din(serial_channel_one_din), .serial_channel_zero_din(serial_channel_zero_din),
		.low_power_hold(low_power_hold), .hs_counter_realtime_out_en(hs_en),
		.rc_osc_freq_ctrl(rc_en));
	pgp_board #(.PULL_EXT(OD_BITS)) board (.clk_sys(clk_sys), .rst_n(rst_n),
		.pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .ext_en(ext_en),
		.ext_val(ext_val), .pin_in(pin_in));
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] dt);
		bus <= '{addr: a, wdata: dt, wr: 1'b1, rd: 1'b0, rmw: 1'b0};
		@(posedge clk_sys);
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic m, input logic [7:0] x);
		exp_q.push_back(x);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, rmw: m};
		@(posedge clk_sys);
	endtask : rd
	// Ends on a falling edge so that registered outputs have settled
	task automatic idle(input int n);
		bus <= '0;
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : idle
	task automatic results;
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results
	// ----------------------------------------
	// Read data monitor
	// ----------------------------------------
	always @(posedge clk_sys) rd_seen <= bus.rd;
	always @(negedge clk_sys) begin
		if (rd_seen === 1'b1) begin
			chk(rd_data, exp_q.pop_front());
		end
	end
	initial begin
		#100000;
		n_fail++;
		results();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		bus = '0;
		periph = '0;
		rst_n = 1'b0;
		serial_channel_one_active = 1'b0;
		serial_channel_zero_active = 1'b0;
		low_power_hold = 1'b0;
		ext_en = 8'h00;
		ext_val = 8'h00;
		void'($urandom(3999));
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		idle(0);
		chk(pin_oe, 8'h20);
		chk(pin_out | pullup_en, 8'h00);
		@(posedge clk_sys);
		rd(pgp_pkg::ADDR_LATCH, 1'b1, 8'h00);
		rd(pgp_pkg::ADDR_DIR, 1'b0, 8'h00);
		rd(pgp_pkg::ADDR_FUNC, 1'b0, 8'h00);
		rd(pgp_pkg::ADDR_TEST, 1'b0, pgp_pkg::TEST_RD_ONES);
		rd(16'hFE50, 1'b0, 8'h00);
		repeat (6) begin
			l = 8'($urandom);
			d = 8'($urandom);
			v = 8'($urandom);
			ext_en <= ~d;
			ext_val <= v;
			wr(pgp_pkg::ADDR_LATCH, l);
			wr(pgp_pkg::ADDR_DIR, d);
			wr(pgp_pkg::ADDR_FUNC, 8'h00);
			rd(pgp_pkg::ADDR_LATCH, 1'b1, l);
			rd(pgp_pkg::ADDR_LATCH, 1'b0, (l & d) | (v & ~d));
			idle(1);
			chk(pin_oe, d & ~(OD_BITS & l));
			chk(pin_out & d, l & d);
			chk(pullup_en, l & ~d);
			@(posedge clk_sys);
		end
		ext_en <= 8'h00;
		wr(pgp_pkg::ADDR_DIR, 8'hFF);
		wr(pgp_pkg::ADDR_FUNC, 8'hFF);
		repeat (8) begin
			l = 8'($urandom);
			s = 1'($urandom);
			periph <= pgp_pkg::pgp_periph_t'($urandom);
			wr(pgp_pkg::ADDR_LATCH, l);
			wr(pgp_pkg::ADDR_INSEL, {4'h0, s, 3'h0});
			idle(2);
			e = {(s ? periph.buzzer_output : periph.pwm_high_output) ^ l[7],
				periph.pwm_low_output ^ l[6], periph[5:0] | l[5:0]};
			chk(pin_out, e);
			@(posedge clk_sys);
		end
		// Reserved test bits are only ever written as zero
		wr(pgp_pkg::ADDR_TEST, pgp_pkg::TEST_WMASK);
		rd(pgp_pkg::ADDR_TEST, 1'b0, pgp_pkg::TEST_WMASK | pgp_pkg::TEST_RD_ONES);
		wr(pgp_pkg::ADDR_TEST, 8'h20);
		idle(2);
		chk({6'h00, hs_en, rc_en}, 8'h01);
		@(posedge clk_sys);
		v = 8'($urandom);
		wr(pgp_pkg::ADDR_DIR, 8'h00);
		ext_en <= 8'hFF;
		ext_val <= v;
		serial_channel_one_active <= 1'b1;
		serial_channel_zero_active <= 1'b1;
		idle(3);
		chk({6'h00, serial_channel_one_din, serial_channel_zero_din}, {6'h00, v[4], v[1]});
		@(posedge clk_sys);
		ext_en <= 8'h00;
		wr(pgp_pkg::ADDR_FUNC, 8'h00);
		wr(pgp_pkg::ADDR_LATCH, 8'h5A);
		wr(pgp_pkg::ADDR_DIR, 8'hFF);
		idle(2);
		chk({6'h00, serial_channel_one_din, serial_channel_zero_din}, 8'h03);
		@(posedge clk_sys);
		low_power_hold <= 1'b1;
		wr(pgp_pkg::ADDR_LATCH, 8'hA5);
		idle(3);
		chk(pin_out, 8'h5A);
		@(posedge clk_sys);
		low_power_hold <= 1'b0;
		idle(2);
		chk(pin_out, 8'hA5);
		results();
	end
endmodule : tb_pgp_port1
`default_nettype wire
